// [rtl/oled_setting_map.svh]
`ifndef OLED_SETTING_MAP_SVH
`define OLED_SETTING_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_BYTE_IN 8'h00
`define OFS_STATUS 8'h04
`define OFS_CLOCK 8'h08
`define OFS_ENHANCE 8'h0c
`define OFS_PINS 8'h10
`define OFS_PRECHARGE 8'h14
`define OFS_CONTRAST 8'h18
`define GRAY_PAGE 2'h1
`define DC_BIT 8
`define STATUS_REJECT_BIT 2

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_GRAY_ENABLE 8'h00
`define CMD_CLOCK 8'hb3
`define CMD_ENH_A 8'hb4
`define CMD_PINS 8'hb5
`define CMD_PRECH2 8'hb6
`define CMD_GRAY_LOAD 8'hb8
`define CMD_GRAY_LINEAR 8'hb9
`define CMD_PRECH_V 8'hbb
`define CMD_DESELECT 8'hbe
`define CMD_CONTRAST 8'hc1
`define CMD_MASTER 8'hc7
`define CMD_MUX 8'hca
`define CMD_ENH_B 8'hd1
`define CMD_LOCK 8'hfd

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define RST_DIVIDE 4'h0
`define RST_OSC 4'h5
`define RST_SEGLV 2'h2
`define RST_ENHA 5'h16
`define RST_PINMODE 2'h2
`define RST_PRECH2 4'h8
`define RST_PRECHV 5'h17
`define RST_DESEL 3'h4
`define RST_CONTRAST 8'h7f
`define RST_MASTER 4'hf
`define RST_MUX 7'h7f
`define RST_ENHB 2'h2
`define LOCK_BIT 2
`define DIVIDE_MAX 4'ha
`define MUX_MIN 7'h0f
`define SEGLV_EXT 2'h0
`define SEGLV_INT 2'h2
`define GRAY_MAX 8'hb4
`define GRAY_LAST 4'hf
`define COUNT_NONE 4'h0
`define COUNT_ONE 4'h1
`define COUNT_TWO 4'h2
`define COUNT_GRAY 4'hf

`endif

// [rtl/oled_setting_pkg.sv]
package oled_setting_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PARAM = 3'b010,
		ST_SKIP = 3'b100
	} decode_state_t;

endpackage : oled_setting_pkg

// [rtl/sync_two_stage.sv]
`timescale 1ns/1ps
`default_nettype none

module sync_two_stage #(
	parameter int WIDTH = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] async_level,
	output logic [WIDTH-1:0] sync_level
);

	logic [WIDTH-1:0] first_r;
	logic [WIDTH-1:0] second_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			first_r <= '0;
			second_r <= '0;
		end else begin
			first_r <= async_level;
			second_r <= first_r;
		end
	end

	assign sync_level = second_r;

endmodule : sync_two_stage

`default_nettype wire

// [rtl/oled_setting_command_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
`include "oled_setting_map.svh"

// Functional notes
// - Low nibble sets power-of-two clock divide
// - High nibble sets oscillator frequency level
// - Enhancement A selects low voltage, quality
// - Two pins configured by 2-bit modes
// - Second pre-charge period code, reset 8
// - Gray load takes next 15 bytes
// - Enable command activates last loaded table
// - Linear table: steps of 8, 112 top
// - Pre-charge voltage code, 5 bits, 17h
// - Deselect voltage code, 3 bits, 04h
// - Contrast current full byte, reset 7Fh
// - Master contrast scales currents, reset 1111b
// - Multiplex ratio is parameter plus one
// - Enhancement B: mode bits, fixed 20h
// - Lock rejects every command except lock
module oled_setting_command_decoder (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [3:0] clock_divide_setting,
	output logic [3:0] oscillator_level,
	output logic [1:0] segment_low_voltage,
	output logic [4:0] low_gray_quality,
	output logic [1:0] enhance_b_mode,
	output logic [3:0] second_precharge,
	output logic [4:0] precharge_level,
	output logic [2:0] common_deselect_level,
	output logic [7:0] segment_drive_current,
	output logic [3:0] master_current,
	output logic [7:0] mux_ratio,
	output logic commands_locked,
	input wire logic [3:0] gray_level_select,
	output logic [7:0] gray_level_width,
	output logic general_pin_zero_drive,
	output logic general_pin_zero_enable,
	input wire logic general_pin_zero_level,
	output logic general_pin_one_drive,
	output logic general_pin_one_enable,
	input wire logic general_pin_one_level
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [3:0] param_count(input logic [7:0] cmd);
		case (cmd)
			`CMD_CLOCK, `CMD_PINS, `CMD_PRECH2, `CMD_PRECH_V, `CMD_DESELECT,
			`CMD_CONTRAST, `CMD_MASTER, `CMD_MUX, `CMD_LOCK: param_count = `COUNT_ONE;
			`CMD_ENH_A, `CMD_ENH_B: param_count = `COUNT_TWO;
			`CMD_GRAY_LOAD: param_count = `COUNT_GRAY;
			default: param_count = `COUNT_NONE;
		endcase
	endfunction : param_count

	function automatic logic [7:0] linear_width(input logic [3:0] level);
		if (level < 4'h2) begin
			linear_width = 8'h00;
		end else begin
			linear_width = {1'b0, level - 4'h1, 3'b000};
		end
	endfunction : linear_width

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	logic aw_hold_r, aw_hold_nxt;
	logic w_hold_r, w_hold_nxt;
	logic [7:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic wr_fire;
	logic wr_mapped;

	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready = !w_hold_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign wr_fire = aw_hold_r && w_hold_r;
	assign wr_mapped = (awaddr_r[7:2] <= `OFS_CONTRAST >> 2) || (awaddr_r[7:6] == `GRAY_PAGE);

	always_comb begin
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt = w_hold_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_mapped ? 2'h0 : 2'h2;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
		end else begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
		end
	end

	logic byte_valid;
	logic byte_is_param;
	logic [7:0] byte_val;
	logic reject_clear;

	assign byte_valid = wr_fire && (awaddr_r == `OFS_BYTE_IN) && wstrb_r[0];
	assign byte_is_param = wdata_r[`DC_BIT];
	assign byte_val = wdata_r[7:0];
	assign reject_clear = wr_fire && (awaddr_r == `OFS_STATUS) && wstrb_r[0]
		&& wdata_r[`STATUS_REJECT_BIT];

	// ----------------------------------------
	// Command decoder and setting store
	// ----------------------------------------
	oled_setting_pkg::decode_state_t state_r, state_nxt;
	logic [7:0] cmd_r, cmd_nxt;
	logic [3:0] idx_r, idx_nxt;
	logic [3:0] divide_r, divide_nxt;
	logic [3:0] osc_r, osc_nxt;
	logic [1:0] seglv_r, seglv_nxt;
	logic [4:0] enha_r, enha_nxt;
	logic [1:0] enhb_r, enhb_nxt;
	logic [3:0] pinmode_r, pinmode_nxt;
	logic [3:0] prech2_r, prech2_nxt;
	logic [4:0] prechv_r, prechv_nxt;
	logic [2:0] desel_r, desel_nxt;
	logic [7:0] contrast_r, contrast_nxt;
	logic [3:0] master_r, master_nxt;
	logic [6:0] mux_r, mux_nxt;
	logic locked_r, locked_nxt;
	logic prog_active_r, prog_active_nxt;
	logic reject_r, reject_nxt;
	logic [7:0] stage_r [15:1];
	logic [7:0] stage_nxt [15:1];
	logic [7:0] active_r [15:1];
	logic [7:0] active_nxt [15:1];
	logic [3:0] idx_inc;
	logic [3:0] gray_level;

	assign idx_inc = idx_r + 4'h1;
	assign gray_level = idx_inc;

	always_comb begin
		state_nxt = state_r;
		cmd_nxt = cmd_r;
		idx_nxt = idx_r;
		divide_nxt = divide_r;
		osc_nxt = osc_r;
		seglv_nxt = seglv_r;
		enha_nxt = enha_r;
		enhb_nxt = enhb_r;
		pinmode_nxt = pinmode_r;
		prech2_nxt = prech2_r;
		prechv_nxt = prechv_r;
		desel_nxt = desel_r;
		contrast_nxt = contrast_r;
		master_nxt = master_r;
		mux_nxt = mux_r;
		locked_nxt = locked_r;
		prog_active_nxt = prog_active_r;
		reject_nxt = reject_r && !reject_clear;
		stage_nxt = stage_r;
		active_nxt = active_r;
		if (byte_valid && !byte_is_param) begin
			cmd_nxt = byte_val;
			idx_nxt = 4'h0;
			if (locked_r && byte_val != `CMD_LOCK) begin
				state_nxt = oled_setting_pkg::ST_SKIP;
				reject_nxt = 1'b1;
			end else if (param_count(byte_val) != `COUNT_NONE) begin
				state_nxt = oled_setting_pkg::ST_PARAM;
			end else if (byte_val == `CMD_GRAY_ENABLE) begin
				state_nxt = oled_setting_pkg::ST_IDLE;
				active_nxt = stage_r;
				prog_active_nxt = 1'b1;
			end else if (byte_val == `CMD_GRAY_LINEAR) begin
				state_nxt = oled_setting_pkg::ST_IDLE;
				for (int i = 1; i < 16; i++) begin
					active_nxt[i] = linear_width(4'(i));
				end
				prog_active_nxt = 1'b0;
			end else begin
				state_nxt = oled_setting_pkg::ST_SKIP;
			end
		end else if (byte_valid && state_r == oled_setting_pkg::ST_PARAM) begin
			idx_nxt = idx_inc;
			if (idx_inc == param_count(cmd_r)) begin
				state_nxt = oled_setting_pkg::ST_IDLE;
			end
			case (cmd_r)
				`CMD_CLOCK: begin
					if (byte_val[3:0] <= `DIVIDE_MAX) begin
						divide_nxt = byte_val[3:0];
					end
					osc_nxt = byte_val[7:4];
				end
				`CMD_ENH_A: begin
					if (idx_r == 4'h0) begin
						if (byte_val[1:0] == `SEGLV_EXT || byte_val[1:0] == `SEGLV_INT) begin
							seglv_nxt = byte_val[1:0];
						end
					end else begin
						enha_nxt = byte_val[7:3];
					end
				end
				`CMD_PINS: pinmode_nxt = byte_val[3:0];
				`CMD_PRECH2: prech2_nxt = byte_val[3:0];
				`CMD_GRAY_LOAD: begin
					if (byte_val <= `GRAY_MAX) begin
						stage_nxt[gray_level] = byte_val;
					end
				end
				`CMD_PRECH_V: prechv_nxt = byte_val[4:0];
				`CMD_DESELECT: desel_nxt = byte_val[2:0];
				`CMD_CONTRAST: contrast_nxt = byte_val;
				`CMD_MASTER: master_nxt = byte_val[3:0];
				`CMD_MUX: begin
					if (byte_val[6:0] >= `MUX_MIN) begin
						mux_nxt = byte_val[6:0];
					end
				end
				`CMD_ENH_B: begin
					if (idx_r == 4'h0) begin
						enhb_nxt = byte_val[5:4];
					end
				end
				`CMD_LOCK: locked_nxt = byte_val[`LOCK_BIT];
				default: state_nxt = oled_setting_pkg::ST_SKIP;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= oled_setting_pkg::ST_IDLE;
			cmd_r <= 8'h00;
			idx_r <= 4'h0;
			divide_r <= `RST_DIVIDE;
			osc_r <= `RST_OSC;
			seglv_r <= `RST_SEGLV;
			enha_r <= `RST_ENHA;
			enhb_r <= `RST_ENHB;
			pinmode_r <= {`RST_PINMODE, `RST_PINMODE};
			prech2_r <= `RST_PRECH2;
			prechv_r <= `RST_PRECHV;
			desel_r <= `RST_DESEL;
			contrast_r <= `RST_CONTRAST;
			master_r <= `RST_MASTER;
			mux_r <= `RST_MUX;
			locked_r <= 1'b0;
			prog_active_r <= 1'b0;
			reject_r <= 1'b0;
			for (int i = 1; i < 16; i++) begin
				stage_r[i] <= linear_width(4'(i));
				active_r[i] <= linear_width(4'(i));
			end
		end else begin
			state_r <= state_nxt;
			cmd_r <= cmd_nxt;
			idx_r <= idx_nxt;
			divide_r <= divide_nxt;
			osc_r <= osc_nxt;
			seglv_r <= seglv_nxt;
			enha_r <= enha_nxt;
			enhb_r <= enhb_nxt;
			pinmode_r <= pinmode_nxt;
			prech2_r <= prech2_nxt;
			prechv_r <= prechv_nxt;
			desel_r <= desel_nxt;
			contrast_r <= contrast_nxt;
			master_r <= master_nxt;
			mux_r <= mux_nxt;
			locked_r <= locked_nxt;
			prog_active_r <= prog_active_nxt;
			reject_r <= reject_nxt;
			stage_r <= stage_nxt;
			active_r <= active_nxt;
		end
	end

	// ----------------------------------------
	// Pins and setting outputs
	// ----------------------------------------
	logic [1:0] pin_level_sync;

	sync_two_stage #(.WIDTH(2)) pin_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_level({general_pin_one_level, general_pin_zero_level}),
		.sync_level(pin_level_sync)
	);

	assign general_pin_zero_enable = pinmode_r[1];
	assign general_pin_zero_drive = pinmode_r[1] && pinmode_r[0];
	assign general_pin_one_enable = pinmode_r[3];
	assign general_pin_one_drive = pinmode_r[3] && pinmode_r[2];
	assign clock_divide_setting = divide_r;
	assign oscillator_level = osc_r;
	assign segment_low_voltage = seglv_r;
	assign low_gray_quality = enha_r;
	assign enhance_b_mode = enhb_r;
	assign second_precharge = prech2_r;
	assign precharge_level = prechv_r;
	assign common_deselect_level = desel_r;
	assign segment_drive_current = contrast_r;
	assign master_current = master_r;
	assign mux_ratio = {1'b0, mux_r} + 8'h01;
	assign commands_locked = locked_r;

	logic [7:0] gray_width_r, gray_width_nxt;
	logic [1:0] pin_seen;

	// Input level only visible in input-enabled mode
	assign pin_seen[0] = (pinmode_r[1:0] == 2'h1) && pin_level_sync[0];
	assign pin_seen[1] = (pinmode_r[3:2] == 2'h1) && pin_level_sync[1];

	always_comb begin
		gray_width_nxt = (gray_level_select == 4'h0) ? 8'h00 : active_r[gray_level_select];
	end

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [31:0] rd_word;
	logic rd_ok;

	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign gray_level_width = gray_width_r;

	always_comb begin
		rd_word = 32'h00000000;
		rd_ok = 1'b1;
		if (s_axi_araddr[7:6] == `GRAY_PAGE) begin
			if (s_axi_araddr[5:2] != 4'h0) begin
				rd_word[7:0] = active_r[s_axi_araddr[5:2]];
			end
		end else begin
			case (s_axi_araddr)
				`OFS_BYTE_IN: rd_word[7:0] = cmd_r;
				`OFS_STATUS: rd_word = {20'h00000, idx_r, 4'h0, state_r == oled_setting_pkg::ST_PARAM,
					reject_r, prog_active_r, locked_r};
				`OFS_CLOCK: rd_word[7:0] = {osc_r, divide_r};
				`OFS_ENHANCE: rd_word = {18'h00000, enhb_r, 3'h0, enha_r, 2'h0, seglv_r};
				`OFS_PINS: rd_word[5:0] = {pin_seen, pinmode_r};
				`OFS_PRECHARGE: rd_word = {13'h0000, desel_r, 3'h0, prechv_r, 4'h0, prech2_r};
				`OFS_CONTRAST: rd_word = {9'h000, mux_r, 4'h0, master_r, contrast_r};
				default: rd_ok = 1'b0;
			endcase
		end
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = rd_word;
			rresp_nxt = rd_ok ? 2'h0 : 2'h2;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= 2'h0;
			gray_width_r <= 8'h00;
		end else begin
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			gray_width_r <= gray_width_nxt;
		end
	end

endmodule : oled_setting_command_decoder

`default_nettype wire

// [verification/pin_partner.sv]
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
	input wire logic zero_enable,
	input wire logic zero_drive,
	input wire logic one_enable,
	input wire logic one_drive,
	output logic zero_level,
	output logic one_level
);
	// Board pull-ups hold released pins high
	assign zero_level = zero_enable ? zero_drive : 1'b1;
	assign one_level = one_enable ? one_drive : 1'b1;
endmodule : pin_partner

`default_nettype wire

// [verification/oled_setting_properties.sv]
`timescale 1ns/1ps
`default_nettype none

module oled_setting_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] clock_divide_setting,
	input wire logic [7:0] segment_drive_current,
	input wire logic [3:0] master_current,
	input wire logic [7:0] mux_ratio,
	input wire logic commands_locked,
	input wire logic general_pin_zero_drive,
	input wire logic general_pin_zero_enable,
	input wire logic general_pin_one_drive,
	input wire logic general_pin_one_enable
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	bresp_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped");
	rdata_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read data dropped");
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Read answer late");
	ready_block_a: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("Write taken during response");
	divide_valid_a: assert property (
		clock_divide_setting <= 4'ha)
		else $error("Divide code out of range");
	mux_range_a: assert property (
		mux_ratio >= 8'h10 && mux_ratio <= 8'h80)
		else $error("Mux ratio out of range");
	pin_mode_a: assert property (
		!(general_pin_zero_drive && !general_pin_zero_enable)
		&& !(general_pin_one_drive && !general_pin_one_enable))
		else $error("Pin driven high while released");
	pin_write_a: assert property (
		$changed({general_pin_one_enable, general_pin_one_drive, general_pin_zero_enable,
		general_pin_zero_drive}) |-> $rose(s_axi_bvalid))
		else $error("Pin mode changed without write");
	reset_values_a: assert property (
		$rose(aresetn) |-> segment_drive_current == 8'h7f && master_current == 4'hf
		&& mux_ratio == 8'h80 && clock_divide_setting == 4'h0)
		else $error("Setting reset value wrong");
	contrast_write_a: assert property (
		$changed(segment_drive_current) |-> $rose(s_axi_bvalid))
		else $error("Contrast changed without write");
	lock_write_a: assert property (
		$changed(commands_locked) |-> $rose(s_axi_bvalid))
		else $error("Lock changed without write");
	cover property ($rose(commands_locked));
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	cover property ($changed(mux_ratio));
endmodule : oled_setting_properties

bind oled_setting_command_decoder oled_setting_properties u_oled_setting_properties (.*);

`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [3:0] gray_level_select = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, segment_low_voltage, enhance_b_mode;
	logic [31:0] s_axi_rdata;
	logic [3:0] clock_divide_setting, oscillator_level, second_precharge, master_current;
	logic [4:0] low_gray_quality, precharge_level;
	logic [2:0] common_deselect_level;
	logic [7:0] segment_drive_current, mux_ratio, gray_level_width;
	logic commands_locked, general_pin_zero_drive, general_pin_zero_enable;
	logic general_pin_zero_level, general_pin_one_drive, general_pin_one_enable;
	logic general_pin_one_level;
	int dv = 0, os = 5, sl = 2, ea = 'h16, eb = 2, pm = 'ha, p2 = 8, pv = 'h17, ds = 4;
	int ct = 'h7f, ms = 15, mx = 127, lk = 0, rj = 0, cur = -1, idx = 0;
	int fails = 0, check_count = 0;
	int gs[16], ga[16];
	logic [7:0] cmds[10] = '{8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hbb, 8'hbe, 8'hc1, 8'hc7, 8'hca, 8'hd1};
	logic [7:0] c;
	logic [1:0] r;
	logic [31:0] d;

	always #4 aclk = ~aclk;

	oled_setting_command_decoder u_oled_setting_command_decoder (.*);
	pin_partner u_pin_partner (.zero_enable(general_pin_zero_enable),
		.zero_drive(general_pin_zero_drive), .one_enable(general_pin_one_enable),
		.one_drive(general_pin_one_drive), .zero_level(general_pin_zero_level),
		.one_level(general_pin_one_level));

	// ----------------------------------------
	// Reference model and bus tasks
	// ----------------------------------------
	function automatic int lin(int i);
		return i < 2 ? 0 : (i - 1) * 8;
	endfunction : lin

	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic limit(input int n);
		if (n >= 60) begin
			fails++;
			print_verdict;
		end
	endtask : limit

	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] e);
		int n;
		bit ta;
		bit tw;
		n = 0;
		ta = 0;
		tw = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'($urandom % 2);
		do begin
			@(posedge aclk);
			if (s_axi_awready && !ta) begin
				ta = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !tw) begin
				tw = 1;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
			n++;
		end while (!(s_axi_bvalid && s_axi_bready) && n < 60);
		limit(n);
		e = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] e);
		int n;
		bit t;
		n = 0;
		t = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'($urandom % 2);
		do begin
			@(posedge aclk);
			if (s_axi_arready && !t) begin
				t = 1;
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
			n++;
		end while (!(s_axi_rvalid && s_axi_rready) && n < 60);
		limit(n);
		q = s_axi_rdata;
		e = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic mdl(input bit dc, input int b);
		if (!dc) begin
			rj = rj | (lk && b != 8'hfd);
			cur = (lk && b != 8'hfd) ? -1 : b;
			idx = 0;
			if (cur == 0) ga = gs;
			if (cur == 8'hb9) foreach (ga[i]) ga[i] = lin(i);
		end else begin
			case (cur * 16 + idx)
				12'hb30: begin
					os = b / 16;
					if (b % 16 <= 10) dv = b % 16;
				end
				12'hb40: if (b % 4 == 0 || b % 4 == 2) sl = b % 4;
				12'hb41: ea = b / 8;
				12'hb50: pm = b % 16;
				12'hb60: p2 = b % 16;
				12'hbb0: pv = b % 32;
				12'hbe0: ds = b % 8;
				12'hc10: ct = b;
				12'hc70: ms = b % 16;
				12'hca0: if (b % 128 >= 15) mx = b % 128;
				12'hd10: eb = b / 16 % 4;
				12'hfd0: lk = b / 4 % 2;
				default: if (cur == 8'hb8 && idx < 15 && b <= 180) gs[idx + 1] = b;
			endcase
			idx++;
		end
	endtask : mdl

	task automatic sb(input bit dc, input int b);
		wr(8'h00, {23'h0, dc, b[7:0]}, r);
		chk(r, 2'h0);
		mdl(dc, b);
	endtask : sb

	task automatic check_all;
		rd(8'h08, d, r);
		chk(d, os * 16 + dv);
		rd(8'h0c, d, r);
		chk(d, sl + ea * 16 + eb * 4096);
		rd(8'h10, d, r);
		chk(d, pm + (pm % 4 == 1) * 16 + (pm / 4 == 1) * 32);
		rd(8'h14, d, r);
		chk(d, p2 + pv * 256 + ds * 65536);
		rd(8'h18, d, r);
		chk(d, ct + ms * 256 + mx * 65536);
		rd(8'h04, d, r);
		chk(d & 32'h5, lk + rj * 4);
		chk(mux_ratio, mx + 1);
		chk({oscillator_level, clock_divide_setting}, os * 16 + dv);
		chk({enhance_b_mode, low_gray_quality, segment_low_voltage}, eb * 128 + ea * 4 + sl);
		chk({common_deselect_level, precharge_level, second_precharge}, ds * 512 + pv * 16 + p2);
		chk({commands_locked, master_current, segment_drive_current}, lk * 4096 + ms * 256 + ct);
		chk({general_pin_one_enable, general_pin_one_drive, general_pin_zero_enable,
			general_pin_zero_drive}, {pm[3], pm[3] & pm[2], pm[1], pm[1] & pm[0]});
	endtask : check_all

	task automatic check_gray;
		for (int l = 0; l < 16; l++) begin
			gray_level_select <= l[3:0];
			rd(8'h40 + 8'(l * 4), d, r);
			chk(d, ga[l]);
			chk(gray_level_width, ga[l]);
		end
	endtask : check_gray

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(69));
		foreach (gs[i]) gs[i] = lin(i);
		ga = gs;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		check_all;
		check_gray;
		$display("test reset values done");
		for (int n = 0; n < 60; n++) begin
			c = cmds[$urandom % 10];
			sb(0, c);
			sb(1, $urandom % 256);
			sb(1, (c == 8'hd1) ? 8'h20 : $urandom % 256);
			check_all;
		end
		$display("test random settings done");
		sb(0, 8'hb8);
		for (int l = 1; l < 16; l++) sb(1, l * 12 - $urandom % 5);
		check_gray;
		sb(0, 8'h00);
		check_gray;
		sb(0, 8'hb8);
		sb(1, 200);
		sb(0, 8'hc1);
		sb(1, 8'h3c);
		sb(0, 8'h00);
		check_gray;
		sb(0, 8'hb9);
		check_gray;
		check_all;
		$display("test gray tables done");
		sb(0, 8'hfd);
		sb(1, 8'h16);
		sb(0, 8'hc1);
		sb(1, 8'h21);
		sb(0, 8'hb9);
		check_all;
		sb(0, 8'hfd);
		sb(1, 8'h12);
		wr(8'h04, 32'h4, r);
		chk(r, 2'h0);
		rj = 0;
		sb(1, 8'h55);
		check_all;
		$display("test lock done");
		wr(8'h30, 32'h1, r);
		chk(r, 2'h2);
		rd(8'h30, d, r);
		chk(d, 32'h0);
		chk(r, 2'h2);
		$display("test unmapped done");
		print_verdict;
	end
endmodule : tb_top

`default_nettype wire
